// File: hw/dpsc_top.sv
// Purpose: serial command decoder of a single 256-tap digital pot
// Assumes: pins sampled by clk_i; serial clock well under clk_i / 8
// Notes: stored settings live in flops; the write cycle is timed only
`default_nettype none
module dpsc_top
    import dpsc_pkg::*;
#(
    parameter int WRITE_CYC = dpsc_pkg::DPSC_WRITE_CYC,
    parameter logic [3:0] DEVICE_TYPE = 4'h3 // arbitrary value
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // serial link
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic si_i,
    output logic so_o,
    output logic so_oe_o,
    // straps and protection
    input wire logic [1:0] pin_address_bits_i,
    input wire logic wp_n_i,
    // pot and status
    output logic [7:0] wiper_o,
    output logic write_in_progress_flag_o
);
    import dpsc_pkg::*;

    logic sck_rise, sck_fall;
    logic cs_s, cs_rise, cs_fall;
    logic si_s;
    logic [1:0] addr_m_q, addr_s_q;
    logic wp_m_q, wp_s_q;

    dpsc_sync #(.RST_VAL(1'b0)) u_sck (.clk_i(clk_i), .nrst_i(nrst_i),
        .pin_i(sck_i), .level_o(), .rise_o(sck_rise),
        .fall_o(sck_fall));
    // select idles high; a low reset value would fake a select edge
    dpsc_sync #(.RST_VAL(1'b1)) u_cs (.clk_i(clk_i), .nrst_i(nrst_i),
        .pin_i(cs_n_i), .level_o(cs_s), .rise_o(cs_rise),
        .fall_o(cs_fall));
    dpsc_sync #(.RST_VAL(1'b0)) u_si (.clk_i(clk_i), .nrst_i(nrst_i),
        .pin_i(si_i), .level_o(si_s), .rise_o(),
        .fall_o());

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            addr_m_q <= 2'h0;
            addr_s_q <= 2'h0;
            wp_m_q <= 1'b0;
            wp_s_q <= 1'b0;
        end else begin
            addr_m_q <= pin_address_bits_i;
            addr_s_q <= addr_m_q;
            wp_m_q <= wp_n_i;
            wp_s_q <= wp_m_q;
        end
    end

    dpsc_state_type state_q;
    logic [2:0] bit_q;
    logic [7:0] shin_q;
    logic [7:0] shout_q;
    logic [3:0] op_q;
    logic [3:0] sel_q;
    logic [7:0] wdata_q;
    logic commit_q;
    logic [7:0] wiper_position_register_q;
    logic [7:0] stored_q [DPSC_NUM_REGS];
    logic [7:0] in_byte;
    logic byte_done;
    logic active;
    logic nv_busy, nv_done, nv_start;
    logic [3:0] nv_sel_q;
    logic [7:0] nv_data_q;
    logic wiper_load;

    assign active = !cs_s;
    assign in_byte = {shin_q[6:0], si_s};
    assign byte_done = sck_rise && (bit_q == DPSC_BIT_LAST);

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            shin_q <= 8'h00;
            bit_q <= 3'h0;
        end else if (!active || cs_fall) begin
            bit_q <= 3'h0;
            shin_q <= 8'h00;
        end else if (sck_rise) begin
            shin_q <= in_byte;
            bit_q <= bit_q + 3'h1;
        end
    end

    // command sequencing
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= DPSC_S_IDLE;
            op_q <= 4'h0;
            sel_q <= 4'h0;
            wdata_q <= 8'h00;
            commit_q <= 1'b0;
        end else if (cs_fall) begin
            state_q <= DPSC_S_ID;
            commit_q <= 1'b0;
        end else if (!active) begin
            state_q <= DPSC_S_IDLE;
            commit_q <= 1'b0;
        end else if (byte_done) begin
            case (state_q)
                DPSC_S_ID: begin
                    if (in_byte[7:4] == DEVICE_TYPE &&
                            in_byte[1:0] == addr_s_q) begin
                        state_q <= DPSC_S_INSTR;
                    end else begin
                        state_q <= DPSC_S_IGNORE;
                    end
                end
                DPSC_S_INSTR: begin
                    op_q <= in_byte[7:4];
                    sel_q <= in_byte[3:0];
                    case (in_byte[7:4])
                        DPSC_OP_RD_WIPER, DPSC_OP_WR_WIPER, DPSC_OP_RD_DATA,
                        DPSC_OP_WR_DATA, DPSC_OP_STATUS:
                            state_q <= DPSC_S_DATA;
                        DPSC_OP_STEP: state_q <= DPSC_S_STEP;
                        DPSC_OP_XFR_TO_WIPER, DPSC_OP_XFR_TO_DATA: begin
                            state_q <= (in_byte[1:0] == DPSC_BANK_POT) ?
                                DPSC_S_DONE : DPSC_S_IGNORE;
                            commit_q <= (in_byte[1:0] == DPSC_BANK_POT);
                        end
                        default: state_q <= DPSC_S_IGNORE;
                    endcase
                end
                DPSC_S_DATA: begin
                    wdata_q <= in_byte;
                    commit_q <= 1'b1;
                    state_q <= DPSC_S_DONE;
                end
                DPSC_S_STEP: state_q <= DPSC_S_STEP;
                // a further whole byte after completion spoils the commit
                DPSC_S_DONE: begin
                    commit_q <= 1'b0;
                    state_q <= DPSC_S_IGNORE;
                end
                default: state_q <= DPSC_S_IGNORE;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            shout_q <= 8'h00;
        end else if (state_q == DPSC_S_INSTR && byte_done) begin
            case (in_byte[7:4])
                DPSC_OP_RD_WIPER: shout_q <= wiper_position_register_q;
                DPSC_OP_RD_DATA: shout_q <= stored_q[in_byte[3:0]];
                DPSC_OP_STATUS: shout_q <= {7'h00, nv_busy};
                default: shout_q <= 8'h00;
            endcase
        end else if (state_q == DPSC_S_DATA && sck_fall && bit_q != 3'h0) begin
            shout_q <= {shout_q[6:0], 1'b0};
        end
    end

    // drive only while selected in a read
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            so_oe_o <= 1'b0;
            so_o <= 1'b0;
        end else begin
            so_oe_o <= active && state_q == DPSC_S_DATA &&
                (op_q == DPSC_OP_RD_WIPER || op_q == DPSC_OP_RD_DATA ||
                 op_q == DPSC_OP_STATUS);
            so_o <= shout_q[7];
        end
    end

    logic commit_go;
    logic is_nv_op;
    assign is_nv_op = (op_q == DPSC_OP_WR_DATA) ||
        (op_q == DPSC_OP_XFR_TO_DATA);
    assign commit_go = cs_rise && commit_q;
    // protect and busy block stored writes
    assign nv_start = commit_go && is_nv_op && wp_s_q && !nv_busy;

    dpsc_timer #(.CYCLES(WRITE_CYC)) u_nv (.clk_i(clk_i), .nrst_i(nrst_i),
        .start_i(nv_start), .busy_o(nv_busy), .done_o(nv_done));

    assign write_in_progress_flag_o = nv_busy;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            nv_sel_q <= 4'h0;
            nv_data_q <= 8'h00;
        end else if (nv_start) begin
            nv_sel_q <= (op_q == DPSC_OP_XFR_TO_DATA) ?
                {sel_q[3:2], DPSC_BANK_POT} : sel_q;
            nv_data_q <= (op_q == DPSC_OP_XFR_TO_DATA) ?
                wiper_position_register_q : wdata_q;
        end
    end

    // storage commits at the end of the write window
    for (genvar g = 0; g < DPSC_NUM_REGS; g++) begin : g_reg
        always_ff @(posedge clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
                stored_q[g] <= DPSC_RESET_SETTING;
            end else if (nv_done && nv_sel_q == 4'(g)) begin
                stored_q[g] <= nv_data_q;
            end
        end
    end

    // wiper from default register after reset
    logic boot_q;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            boot_q <= 1'b1;
        end else begin
            boot_q <= 1'b0;
        end
    end

    logic xfr_go;
    assign xfr_go = commit_go && op_q == DPSC_OP_XFR_TO_WIPER && !nv_busy;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wiper_position_register_q <= DPSC_RESET_SETTING;
        end else if (boot_q) begin
            wiper_position_register_q <= stored_q[0];
        end else if (commit_go && op_q == DPSC_OP_WR_WIPER) begin
            wiper_position_register_q <= wdata_q;
        end else if (xfr_go) begin
            wiper_position_register_q <= stored_q[{sel_q[3:2], DPSC_BANK_POT}];
        end else if (state_q == DPSC_S_STEP && sck_rise) begin
            if (si_s && wiper_position_register_q != DPSC_WIPER_MAX) begin
                wiper_position_register_q <= wiper_position_register_q + 8'h01;
            end else if (!si_s &&
                    wiper_position_register_q != DPSC_WIPER_MIN) begin
                wiper_position_register_q <= wiper_position_register_q - 8'h01;
            end
        end
    end

    // output lags loads by the settle delay
    assign wiper_load = boot_q || (commit_go && op_q == DPSC_OP_WR_WIPER) ||
        xfr_go || (state_q == DPSC_S_STEP && sck_rise);
    logic settle_busy, settle_done;
    dpsc_timer #(.CYCLES(DPSC_SETTLE_CYC)) u_settle (.clk_i(clk_i),
        .nrst_i(nrst_i), .start_i(wiper_load), .busy_o(settle_busy),
        .done_o(settle_done));

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wiper_o <= DPSC_RESET_SETTING;
        end else if (settle_done) begin
            wiper_o <= wiper_position_register_q;
        end
    end

    // checks
    default clocking cb_chk @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    // byte ends counted only inside a live select, as the sequencer does
    sequence s_id_byte;
        state_q == DPSC_S_ID && byte_done && active && !cs_fall;
    endsequence
    sequence s_instr_byte;
        state_q == DPSC_S_INSTR && byte_done && active && !cs_fall;
    endsequence
    sequence s_step_clk;
        state_q == DPSC_S_STEP && sck_rise;
    endsequence
    sequence s_nv_ready;
        commit_q && is_nv_op && wp_s_q && !nv_busy;
    endsequence

    a_flag_len: assert property (
        nv_start |=> write_in_progress_flag_o)
        else $error("flag not set after write start");
    a_protect_block: assert property (
        !wp_s_q |-> !nv_start)
        else $error("write started under protect");
    a_so_idle: assert property (
        cs_s |=> !so_oe_o)
        else $error("output driven while deselected");
    a_busy_ignore: assert property (
        nv_busy |-> !nv_start)
        else $error("write started while busy");
    a_step_max: assert property (
        s_step_clk ##0 (si_s && wiper_position_register_q == DPSC_WIPER_MAX)
        |=> wiper_position_register_q == DPSC_WIPER_MAX)
        else $error("wiper wrapped above top");
    a_step_min: assert property (
        s_step_clk ##0 (!si_s && wiper_position_register_q == DPSC_WIPER_MIN)
        |=> wiper_position_register_q == DPSC_WIPER_MIN)
        else $error("wiper wrapped below bottom");
    a_step_up: assert property (
        s_step_clk ##0 (si_s && wiper_position_register_q != DPSC_WIPER_MAX)
        |=> wiper_position_register_q ==
            $past(wiper_position_register_q) + 8'h01)
        else $error("step up missed");
    a_step_down: assert property (
        s_step_clk ##0 (!si_s && wiper_position_register_q != DPSC_WIPER_MIN)
        |=> wiper_position_register_q ==
            $past(wiper_position_register_q) - 8'h01)
        else $error("step down missed");
    a_settle_lag: assert property (
        settle_busy && !settle_done |=> $stable(wiper_o))
        else $error("wiper output moved early");
    a_commit_end: assert property (
        nv_start && op_q == DPSC_OP_WR_DATA |=> nv_data_q == $past(wdata_q))
        else $error("wrong write data latched");
    a_no_commit: assert property (
        cs_rise && !commit_q |-> !nv_start)
        else $error("incomplete sequence committed");
    a_commit_go: assert property (
        s_nv_ready ##0 cs_rise |-> nv_start)
        else $error("complete write not committed");
    a_type_reject: assert property (
        s_id_byte ##0 (in_byte[7:4] != DEVICE_TYPE)
        |=> state_q == DPSC_S_IGNORE)
        else $error("foreign device type accepted");
    a_addr_reject: assert property (
        s_id_byte ##0 (in_byte[1:0] != addr_s_q)
        |=> state_q == DPSC_S_IGNORE)
        else $error("foreign address accepted");
    a_xfr_bank: assert property (
        s_instr_byte ##0 (in_byte[7:4] == DPSC_OP_XFR_TO_WIPER ||
            in_byte[7:4] == DPSC_OP_XFR_TO_DATA) ##0
            (in_byte[1:0] != DPSC_BANK_POT)
        |=> state_q == DPSC_S_IGNORE && !commit_q)
        else $error("transfer outside bank 0 accepted");
    a_xfr_load: assert property (
        xfr_go && !boot_q
        |=> wiper_position_register_q ==
            $past(stored_q[{sel_q[3:2], DPSC_BANK_POT}]))
        else $error("transfer loaded wrong register");
    a_status_byte: assert property (
        s_instr_byte ##0 (in_byte[7:4] == DPSC_OP_STATUS)
        |=> shout_q == {7'h00, $past(write_in_progress_flag_o)})
        else $error("status byte malformed");
endmodule
`default_nettype wire

// File: hw/dpsc_pkg.sv
// Purpose: constants for the serial command decoder of a 256-tap pot
// Assumes: 20 MHz system clock, serial clock far slower and sampled
// Notes: the device type value is a parameter of the top, kept neutral
`default_nettype none
package dpsc_pkg;
    localparam int DPSC_CLK_HZ = 20_000_000;
    localparam int DPSC_SETTLE_US = 5;
    localparam int DPSC_SETTLE_CYC = DPSC_SETTLE_US * (DPSC_CLK_HZ / 1_000_000);
    localparam int DPSC_WRITE_MS = 10;
    localparam int DPSC_WRITE_CYC = DPSC_WRITE_MS * (DPSC_CLK_HZ / 1000);
    localparam logic [3:0] DPSC_OP_RD_WIPER = 4'h9;
    localparam logic [3:0] DPSC_OP_WR_WIPER = 4'ha;
    localparam logic [3:0] DPSC_OP_RD_DATA = 4'hb;
    localparam logic [3:0] DPSC_OP_WR_DATA = 4'hc;
    localparam logic [3:0] DPSC_OP_XFR_TO_WIPER = 4'hd;
    localparam logic [3:0] DPSC_OP_XFR_TO_DATA = 4'he;
    localparam logic [3:0] DPSC_OP_STEP = 4'h2;
    localparam logic [3:0] DPSC_OP_STATUS = 4'h5;
    localparam logic [2:0] DPSC_BIT_LAST = 3'h7;
    localparam logic [7:0] DPSC_WIPER_MAX = 8'hff;
    localparam logic [7:0] DPSC_WIPER_MIN = 8'h00;
    localparam logic [7:0] DPSC_RESET_SETTING = 8'h80;
    localparam logic [1:0] DPSC_BANK_POT = 2'h0;
    localparam int DPSC_NUM_REGS = 16;
    typedef enum logic [2:0] {
        DPSC_S_IDLE, DPSC_S_ID, DPSC_S_INSTR, DPSC_S_DATA, DPSC_S_STEP,
        DPSC_S_DONE, DPSC_S_IGNORE
    } dpsc_state_type;
endpackage
`default_nettype wire

// File: hw/dpsc_sync.sv
// Purpose: two-flop synchroniser with edge detection for the serial pins
// Assumes: pins are asynchronous to clk_i
// Notes: edges come from the second and third flops, never the first
`default_nettype none
module dpsc_sync #(
    parameter logic RST_VAL = 1'b0
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // pin and synchronised views
    input wire logic pin_i,
    output logic level_o,
    output logic rise_o,
    output logic fall_o
);
    logic meta_q;
    logic sync_q;
    logic last_q;

    // reset to the pin's idle level, else a false edge follows reset
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
            last_q <= RST_VAL;
        end else begin
            meta_q <= pin_i;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign level_o = sync_q;
    assign rise_o = sync_q & ~last_q;
    assign fall_o = ~sync_q & last_q;
endmodule
`default_nettype wire

// File: hw/dpsc_timer.sv
// Purpose: down counter that marks a busy window of a given length
// Assumes: start is a one-cycle pulse
// Notes: a new start while busy restarts the window
`default_nettype none
module dpsc_timer #(
    parameter int CYCLES = 100
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // control
    input wire logic start_i,
    output logic busy_o,
    output logic done_o
);
    localparam int W = $clog2(CYCLES + 1);
    localparam logic [W-1:0] LOAD = W'(CYCLES);
    logic [W-1:0] cnt_q;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_q <= '0;
        end else if (start_i) begin
            cnt_q <= LOAD;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - W'(1);
        end
    end

    assign busy_o = (cnt_q != '0);
    assign done_o = (cnt_q == W'(1)) && !start_i;
endmodule
`default_nettype wire

// File: dv/dpsc_host.sv
// Purpose: serial host model that frames commands for the pot decoder
// Assumes: serial clock of 400 ns made from clk_i, idle low between frames
// Notes: read bits are taken late in the high phase, since the device
// launches on the fall but its output lags the pin by a few clocks
`default_nettype none
module dpsc_host (
    // clock
    input wire logic clk_i,
    // serial link
    input wire logic so_i,
    input wire logic so_oe_i,
    output logic sck_o,
    output logic cs_n_o,
    output logic si_o
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic frame(input logic [3:0] dtype, input logic [1:0] addr,
        input logic [7:0] instr, input logic [7:0] data, input int extra,
        output logic [7:0] rx);
        logic [23:0] bits;
        int i;
        // type, two zeros, address, then instruction
        bits = {dtype, 2'b00, addr, instr, data};
        rx = 8'h00;
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        wait_clk(4);
        for (i = 0; i < 16 + extra; i++) begin
            si_o <= bits[23 - i];
            wait_clk(4);
            // input held across the rising edge
            sck_o <= 1'b1;
            wait_clk(4);
            rx = {rx[6:0], so_oe_i ? so_i : ~rx[0]};
            sck_o <= 1'b0;
        end
        wait_clk(4);
        cs_n_o <= 1'b1;
        // a released line must not keep showing the last bit
        si_o <= ~si_o;
        // deselect time before the next frame
        wait_clk(40);
    endtask
endmodule
`default_nettype wire

// File: dv/test_digipot_spi_command_decoder.sv
// Purpose: self-checking bench for the serial pot command decoder
// Assumes: write window shortened through WRITE_CYC
// Notes: expected values come from a local copy of the stored settings
`default_nettype none
module test_digipot_spi_command_decoder import dpsc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int WCYC = 1000;
    localparam int LIMIT = 80000;
    localparam logic [3:0] DTYPE = 4'h6; // arbitrary value
    localparam logic [1:0] ADDR = 2'h2;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [1:0] pin_address_bits_i = ADDR;
    logic wp_n_i = 1'b1;
    logic sck, cs_n, si, so, so_oe, flag;
    logic [7:0] wiper, rx, v, d;
    logic [3:0] sel;
    logic [7:0] store [16];
    int errors = 0;
    int checks = 0;
    int seed = 38;
    int cycles = 0;
    int k;

    dpsc_top #(.WRITE_CYC(WCYC), .DEVICE_TYPE(DTYPE)) i_dpsc_top (
        .clk_i(clk_i), .nrst_i(nrst_i), .sck_i(sck), .cs_n_i(cs_n),
        .si_i(si), .so_o(so), .so_oe_o(so_oe),
        .pin_address_bits_i(pin_address_bits_i), .wp_n_i(wp_n_i),
        .wiper_o(wiper), .write_in_progress_flag_o(flag));
    dpsc_host i_dpsc_host (.clk_i(clk_i), .so_i(so), .so_oe_i(so_oe),
        .sck_o(sck), .cs_n_o(cs_n), .si_o(si));

    always #25 clk_i = ~clk_i;

    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == LIMIT) begin
            errors++;
            print_verdict();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cmd(input logic [3:0] op, input logic [3:0] s,
        input logic [7:0] data, input int extra);
        i_dpsc_host.frame(DTYPE, ADDR, {op, s}, data, extra, rx);
    endtask

    task automatic wait_done();
        int n;
        n = 0;
        while (flag !== 1'b0 && n < 2 * WCYC) begin
            @(posedge clk_i);
            n++;
        end
    endtask

    // saturating step of the wiper, one move per extra bit
    function automatic logic [7:0] stepped(input logic [7:0] w,
        input logic [7:0] bits, input int n);
        int i;
        for (i = 0; i < n; i++) begin
            if (bits[7 - i] && w != DPSC_WIPER_MAX) w = w + 8'h01;
            else if (!bits[7 - i] && w != DPSC_WIPER_MIN) w = w - 8'h01;
        end
        return w;
    endfunction

    task automatic step_case(input logic [7:0] w0, input logic [7:0] bits,
        input int n);
        cmd(DPSC_OP_WR_WIPER, 4'h0, w0, 8);
        cmd(DPSC_OP_STEP, 4'h0, bits, n);
        cmd(DPSC_OP_RD_WIPER, 4'h0, 8'h00, 8);
        check(rx, stepped(w0, bits, n));
    endtask

    initial begin
        for (k = 0; k < 16; k++) store[k] = DPSC_RESET_SETTING;
        repeat (3) @(posedge clk_i);
        nrst_i <= 1'b1;
        i_dpsc_host.wait_clk(110);
        check({7'h00, so_oe}, 8'h00);
        check(wiper, DPSC_RESET_SETTING);
        cmd(DPSC_OP_STATUS, 4'h1, 8'h00, 8);
        check(rx, 8'h00);
        v = $random(seed);
        if (v == DPSC_RESET_SETTING) v = 8'h5a;
        cmd(DPSC_OP_WR_WIPER, 4'h0, v, 8);
        check(wiper, DPSC_RESET_SETTING);
        i_dpsc_host.wait_clk(100);
        check(wiper, v);
        i_dpsc_host.frame(~DTYPE, ADDR, {DPSC_OP_WR_WIPER, 4'h0}, ~v, 8, rx);
        i_dpsc_host.frame(DTYPE, ~ADDR, {DPSC_OP_WR_WIPER, 4'h0}, ~v, 8, rx);
        cmd(DPSC_OP_RD_WIPER, 4'h0, 8'h00, 8);
        check(rx, v);
        for (k = 0; k < 4; k++) begin
            sel = $random(seed);
            d = $random(seed);
            cmd(DPSC_OP_WR_DATA, sel, d, 8);
            check({7'h00, flag}, 8'h01);
            cmd(DPSC_OP_WR_DATA, sel ^ 4'h4, ~d, 8);
            cmd(DPSC_OP_STATUS, 4'h1, 8'h00, 8);
            check(rx, 8'h01);
            wait_done();
            check({7'h00, flag}, 8'h00);
            store[sel] = d;
            cmd(DPSC_OP_RD_DATA, sel, 8'h00, 8);
            check(rx, d);
            cmd(DPSC_OP_RD_DATA, sel ^ 4'h4, 8'h00, 8);
            check(rx, store[sel ^ 4'h4]);
        end
        cmd(DPSC_OP_WR_DATA, sel, ~d, 4);
        check({7'h00, flag}, 8'h00);
        wp_n_i <= 1'b0;
        cmd(DPSC_OP_WR_DATA, sel, ~d, 8);
        wait_done();
        wp_n_i <= 1'b1;
        cmd(DPSC_OP_RD_DATA, sel, 8'h00, 8);
        check(rx, d);
        sel = {2'($random(seed)), 2'b00};
        cmd(DPSC_OP_XFR_TO_DATA, sel, 8'h00, 0);
        check({7'h00, flag}, 8'h01);
        wait_done();
        store[sel] = v;
        cmd(DPSC_OP_RD_DATA, sel, 8'h00, 8);
        check(rx, v);
        d = ~v;
        cmd(DPSC_OP_WR_DATA, sel, d, 8);
        wait_done();
        store[sel] = d;
        cmd(DPSC_OP_XFR_TO_WIPER, sel, 8'h00, 0);
        cmd(DPSC_OP_RD_WIPER, 4'h0, 8'h00, 8);
        check(rx, d);
        v = ~store[sel | 4'h1];
        cmd(DPSC_OP_WR_WIPER, 4'h0, v, 8);
        cmd(DPSC_OP_XFR_TO_WIPER, sel | 4'h1, 8'h00, 0);
        cmd(DPSC_OP_RD_WIPER, 4'h0, 8'h00, 8);
        check(rx, v);
        cmd(4'h7, 4'h0, ~v, 8);
        cmd(DPSC_OP_RD_WIPER, 4'h0, 8'h00, 8);
        check(rx, v);
        step_case(8'hfd, 8'hf0, 4);
        step_case(8'hfe, 8'ha0, 4);
        step_case(8'h02, 8'h00, 4);
        step_case(8'($random(seed)), 8'($random(seed)), 8);
        print_verdict();
    end
endmodule
`default_nettype wire
